// >>> hdl/clk_switch_pkg.sv
// Constants, types and decoding shared by the system clock select and switch logic.
// Assumes one 200 MHz sampling clock; every oscillator arrives as a pin level.
package clk_switch_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned WARMUP_NS    = 2000;
  localparam int unsigned WARMUP_CYC   = (WARMUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PLL_LOCK_US  = 2000;
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned OST_COUNT    = 1024;

  // ---------------------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFF      = 4'h0;
  localparam logic [3:0] STAT_OFF      = 4'h1;
  localparam int unsigned CTRL_PLL_BIT  = 7;
  localparam int unsigned CTRL_FREQ_LSB = 3;
  localparam int unsigned CTRL_SCS_LSB  = 0;
  localparam logic       PLL_RST       = 1'b0;
  localparam logic [3:0] FREQ_RST      = 4'h7;
  localparam logic [1:0] SCS_RST       = 2'h0;

  // Configuration oscillator mode codes.
  localparam logic [2:0] MODE_LP     = 3'h0;
  localparam logic [2:0] MODE_XT     = 3'h1;
  localparam logic [2:0] MODE_HS     = 3'h2;
  localparam logic [2:0] MODE_INTERNAL_OSC_BLOCK = 3'h4;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {SRC_EXT = 2'b00, SRC_SEC = 2'b01, SRC_INT = 2'b10, SRC_NONE = 2'b11} src_t;
  typedef enum logic [1:0] {OSC_LF = 2'b00, OSC_MF = 2'b01, OSC_HF = 2'b10, OSC_PLL = 2'b11} osc_t;
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_RUN   = 3'b001,
    ST_START = 3'b010,
    ST_FALL  = 3'b011,
    ST_HOLD  = 3'b100
  } sw_state_t;

  typedef struct packed {
    src_t       src;
    osc_t       osc;
    logic [3:0] dexp;
  } clk_sel_t;

  typedef struct packed {
    logic       ext;
    logic       sec;
    logic       lf;
    logic       mf;
    logic       hf;
    logic       pll;
    logic       sec_rdy;
  } osc_pins_t;

  typedef struct packed {
    logic [2:0] osc_mode;
    logic       pll_enable;
    logic       switchover;
  } cfg_word_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Internal frequency code to oscillator and power-of-two postscaler.
  function automatic clk_sel_t int_select(logic [3:0] code, logic pll_on);
    clk_sel_t r;
    r.src = SRC_INT;
    r.osc = OSC_HF;
    r.dexp = 4'h0;
    case (code)
      4'h0, 4'h1: begin r.osc = OSC_LF; r.dexp = 4'h0; end
      4'h2:       begin r.osc = OSC_MF; r.dexp = 4'h4; end
      4'h3:       begin r.osc = OSC_HF; r.dexp = 4'h9; end
      4'h4:       begin r.osc = OSC_MF; r.dexp = 4'h3; end
      4'h5:       begin r.osc = OSC_MF; r.dexp = 4'h2; end
      4'h6:       begin r.osc = OSC_MF; r.dexp = 4'h1; end
      4'h7:       begin r.osc = OSC_MF; r.dexp = 4'h0; end
      4'h8:       begin r.osc = OSC_HF; r.dexp = 4'h7; end
      4'h9:       begin r.osc = OSC_HF; r.dexp = 4'h6; end
      4'ha:       begin r.osc = OSC_HF; r.dexp = 4'h5; end
      4'hb:       begin r.osc = OSC_HF; r.dexp = 4'h4; end
      4'hc:       begin r.osc = OSC_HF; r.dexp = 4'h3; end
      4'hd:       begin r.osc = OSC_HF; r.dexp = 4'h2; end
      4'he:       begin r.osc = pll_on ? OSC_PLL : OSC_HF; r.dexp = pll_on ? 4'h0 : 4'h1; end
      default:    begin r.osc = OSC_HF; r.dexp = 4'h0; end
    endcase
    return r;
  endfunction : int_select

  // Internal oscillators (LF, MF, HF) that a selection keeps running.
  function automatic logic [2:0] osc_mask(clk_sel_t s);
    logic [2:0] m;
    m = 3'h0;
    if (s.src == SRC_INT) begin
      case (s.osc)
        OSC_LF:  m = 3'h1;
        OSC_MF:  m = 3'h2;
        default: m = 3'h4;
      endcase
    end
    return m;
  endfunction : osc_mask

endpackage : clk_switch_pkg

// >>> hdl/clk_switch.sv
// System clock select and glitch-free switch with two-speed start-up.
// Assumes oscillator outputs arrive as pins sampled by ref_clk, which is much faster than any of them.
// Functional notes
// R1: Any reset loads the internal frequency code 0111, giving 500 kHz.
// R2: 32 MHz needs INTERNAL_OSC_BLOCK mode, code 1110 and the PLL enabled by the software bit or by configuration; source select 1x gives it in any mode.
// R3: Configuration PLL enable keeps the PLL on and removes the 8 MHz choice.
// R4: After a frequency write, start a warm-up if needed, then await the current clock falling.
// R5: Hold system clock low until the new clock rises, then switch and update status.
// R6: A change on the same running oscillator applies with no start-up delay.
// R7: Status reports whether the high, medium and low internal oscillators are active.
// R8: Source select 00 configured source, 01 secondary crystal, 1x internal block.
// R9: Every reset clears the source select field.
// R10: Automatic switches never alter the software source select field.
// R11: Timeout status is set when running from the configured external source.
// R12: Software waits for secondary ready before selecting the secondary oscillator.
// R13: Crystal modes count 1024 oscillations before the oscillator may clock the system.
// R14: Non-crystal modes disable two-speed start-up.
// R15: Reaching 1024 before sleep sets timeout status and moves to the external clock.
// R16: Sleep during start-up aborts the count and leaves timeout status clear.
// R17: Two-speed needs switchover bit 1, source select 00 and a crystal mode.
// R18: Two-speed is entered after power-on (after power-up timer) and after wake.
// R19: Same-source frequency changes finish faster than source changes.
// R20: Leaving sleep or power-on into an internal oscillator waits a warm-up delay.
// R21: Code 000x 31 kHz, 0111 500 kHz, 1110 8 or 32 MHz, 1111 16 MHz.
// R22: With configuration PLL enable set the software bit is ignored; otherwise it alone rules.
// R23: The multiplexer never emits a pulse shorter than a source half period.
`timescale 1ns/1ps

module clk_switch
  import clk_switch_pkg::*;
#(
  parameter int unsigned PLL_LOCK = PLL_LOCK_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Register port
  input  wire reg_req_t   reg_req,
  output logic [7:0]      rdata_q,
  // Configuration and power state
  input  wire cfg_word_t  cfg,
  input  wire logic       sleep_mode,
  input  wire logic       power_up_timer_done,
  // Oscillator pins
  input  wire osc_pins_t  osc_pins,
  // Oscillator enables and system clock
  output logic            lf_en_q,
  output logic            mf_en_q,
  output logic            hf_en_q,
  output logic            pll_en_q,
  output logic            ext_en_q,
  output logic            sysclk_q
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam int unsigned PLL_W = $clog2(PLL_LOCK + 1);

  osc_pins_t          pin_s1_q;
  osc_pins_t          pin_s2_q;
  osc_pins_t          pin_s3_q;
  logic               sw_pll_q;
  logic [3:0]         freq_q;
  logic [1:0]         scs_q;
  sw_state_t          state_q;
  clk_sel_t           cur_q;
  clk_sel_t           sel_q;
  logic               cur_valid_q;
  logic               cur_prev_q;
  logic               new_prev_q;
  logic [8:0]         hf_cnt_q;
  logic [8:0]         mf_cnt_q;
  logic [10:0]        ost_cnt_q;
  logic [8:0]         warm_cnt_q;
  logic [PLL_W-1:0]   pll_cnt_q;
  logic [2:0]         rdy_q;
  logic               pll_rdy_q;
  logic               startup_timeout_status_q;

  logic               pll_on;
  logic               crystal;
  logic               two_speed;
  logic               ost_done;
  logic               ext_ready;
  clk_sel_t           int_sel;
  clk_sel_t           tgt_d;
  logic               cur_lvl;
  logic               new_lvl;
  logic               cur_fall;
  logic               new_rise;
  logic               tgt_ready;
  logic               warm_need;
  logic               warm_done;
  logic [2:0]         warm_set;
  logic [2:0]         en_int_d;
  logic               switching;
  logic               wr_ctrl;
  logic [7:0]         ctrl_rd;
  logic [7:0]         stat_rd;
  logic [7:0]         rd_mux;

  // ---------------------------------------------------------------------------
  // Source level after postscaler
  // ---------------------------------------------------------------------------
  // Pins and dividers are arguments, so the assignments that call this
  // re-evaluate whenever a source level moves.
  function automatic logic sel_level(
    clk_sel_t   s,
    osc_pins_t  p,
    logic [8:0] mf_cnt,
    logic [8:0] hf_cnt
  );
    logic [8:0] c;
    logic       raw;
    logic       lvl;
    c   = (s.osc == OSC_MF) ? mf_cnt : hf_cnt;
    raw = (s.osc == OSC_MF) ? p.mf : p.hf;
    lvl = 1'b0;
    case (s.src)
      SRC_EXT: lvl = p.ext;
      SRC_SEC: lvl = p.sec;
      SRC_INT: begin
        case (s.osc)
          OSC_LF:  lvl = p.lf;
          OSC_PLL: lvl = p.pll;
          default: lvl = (s.dexp == 4'h0) ? raw : c[s.dexp - 4'h1];
        endcase
      end
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction : sel_level

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Nothing but the second stage reads the first.
  // The third stage feeds only the edge detectors.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= osc_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------------------
  // Only crystal modes need settling, so only they start at two speeds.
  assign pll_on    = cfg.pll_enable | sw_pll_q; // R22 R3
  assign crystal   = (cfg.osc_mode == MODE_LP) | (cfg.osc_mode == MODE_XT) | (cfg.osc_mode == MODE_HS);
  assign two_speed = cfg.switchover & (scs_q == 2'b00) & crystal; // R17 R14
  assign ost_done  = (ost_cnt_q == OST_COUNT[10:0]); // R13
  assign ext_ready = crystal ? ost_done : 1'b1;
  assign int_sel   = int_select(freq_q, pll_on); // R21 R2

  // Two-speed picks the internal clock only through the target; the software field is never touched.
  always_comb begin
    tgt_d = int_sel; // R8
    if (scs_q == 2'b01) begin
      tgt_d = '{src: SRC_SEC, osc: OSC_LF, dexp: 4'h0};
    end else if (scs_q == 2'b00 && cfg.osc_mode != MODE_INTERNAL_OSC_BLOCK && !(two_speed && !ost_done)) begin
      tgt_d = '{src: SRC_EXT, osc: OSC_LF, dexp: 4'h0}; // R10 R15
    end
  end

  assign cur_lvl  = sel_level(cur_q, pin_s2_q, mf_cnt_q, hf_cnt_q);
  assign new_lvl  = sel_level(sel_q, pin_s2_q, mf_cnt_q, hf_cnt_q);
  assign cur_fall = cur_prev_q & ~cur_lvl;
  assign new_rise = ~new_prev_q & new_lvl;

  // ---------------------------------------------------------------------------
  // Readiness and warm-up
  // ---------------------------------------------------------------------------
  // Warm-up is timed on ref_clk; a starting oscillator cannot time itself.
  assign switching = (state_q == ST_START) | (state_q == ST_FALL) | (state_q == ST_HOLD);
  assign en_int_d  = (state_q == ST_OFF) ? 3'h0 :
                     ((cur_valid_q ? osc_mask(cur_q) : 3'h0) | (switching ? osc_mask(sel_q) : 3'h0));
  assign warm_need = (state_q == ST_START) & ((osc_mask(sel_q) & ~rdy_q) != 3'h0); // R20
  assign warm_done = warm_need & (warm_cnt_q == 9'(WARMUP_CYC - 1));
  assign warm_set  = warm_done ? osc_mask(sel_q) : 3'h0;

  // Ready is kept only while the oscillator stays enabled, so re-enabling costs another warm-up.
  always_comb begin
    case (sel_q.src)
      SRC_EXT: tgt_ready = ext_ready; // R13
      SRC_SEC: tgt_ready = pin_s2_q.sec_rdy; // R12
      SRC_INT: tgt_ready = ((osc_mask(sel_q) & ~rdy_q) == 3'h0) & ((sel_q.osc != OSC_PLL) | pll_rdy_q);
      default: tgt_ready = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_cnt_q <= 9'h000;
      rdy_q      <= 3'h0;
      pll_cnt_q  <= '0;
      pll_rdy_q  <= 1'b0;
    end else begin
      warm_cnt_q <= (warm_need && !warm_done) ? warm_cnt_q + 9'h001 : 9'h000;
      rdy_q      <= en_int_d & (rdy_q | warm_set); // R7
      // Dropping the enable loses lock at once.
      if (!pll_en_q) begin
        pll_cnt_q <= '0;
        pll_rdy_q <= 1'b0;
      end else if (pll_cnt_q == PLL_W'(PLL_LOCK)) begin
        pll_rdy_q <= 1'b1;
      end else begin
        pll_cnt_q <= pll_cnt_q + PLL_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Postscaler counters and start-up timer
  // ---------------------------------------------------------------------------
  // Dividers count synchronised rising edges of their source.
  // The start-up timer holds at its end count until the oscillator stops.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hf_cnt_q  <= 9'h000;
      mf_cnt_q  <= 9'h000;
      ost_cnt_q <= 11'h000;
    end else begin
      if (pin_s2_q.hf && !pin_s3_q.hf) begin
        hf_cnt_q <= hf_cnt_q + 9'h001;
      end
      if (pin_s2_q.mf && !pin_s3_q.mf) begin
        mf_cnt_q <= mf_cnt_q + 9'h001;
      end
      if (sleep_mode || !ext_en_q) begin
        ost_cnt_q <= 11'h000; // R16
      end else if (!ost_done && pin_s2_q.ext && !pin_s3_q.ext) begin
        ost_cnt_q <= ost_cnt_q + 11'h001; // R13
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------------------
  // Sleep parks the clock low from any state, so a wake always
  // passes through a fresh start before a source is trusted.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_OFF;
      cur_q       <= '{src: SRC_NONE, osc: OSC_LF, dexp: 4'h0};
      sel_q       <= '{src: SRC_NONE, osc: OSC_LF, dexp: 4'h0};
      cur_valid_q <= 1'b0;
      sysclk_q    <= 1'b0;
      startup_timeout_status_q      <= 1'b0;
    end else if (sleep_mode) begin
      state_q     <= ST_OFF; // R16
      cur_valid_q <= 1'b0;
      sysclk_q    <= 1'b0;
      startup_timeout_status_q      <= 1'b0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          sysclk_q <= 1'b0;
          if (power_up_timer_done) begin
            sel_q   <= tgt_d; // R18
            state_q <= ST_START;
          end
        end
        ST_RUN: begin
          // Status follows the running source, not the request.
          sysclk_q <= cur_lvl;
          startup_timeout_status_q   <= (cur_q.src == SRC_EXT); // R11
          if (tgt_d != cur_q) begin
            sel_q   <= tgt_d;
            state_q <= ST_START; // R4
          end
        end
        ST_START: begin
          sysclk_q <= cur_valid_q & cur_lvl;
          // A target that moves while waiting replaces the pending one.
          if (tgt_d != sel_q) begin
            sel_q <= tgt_d;
          end else if (tgt_ready) begin
            state_q <= cur_valid_q ? ST_FALL : ST_HOLD; // R6 R19
          end
        end
        ST_FALL: begin
          sysclk_q <= cur_lvl;
          if (cur_fall) begin
            state_q <= ST_HOLD; // R4 R23
          end
        end
        ST_HOLD: begin
          sysclk_q <= 1'b0; // R5
          // Switch only on a rising edge of the new level, so the
          // output never shows a partial pulse of either source.
          if (new_rise) begin
            cur_q       <= sel_q; // R5 R23
            cur_valid_q <= 1'b1;
            sysclk_q    <= 1'b1;
            state_q     <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Both previous levels reset low, like a stopped oscillator.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_prev_q <= 1'b0;
      new_prev_q <= 1'b0;
    end else begin
      cur_prev_q <= cur_lvl;
      new_prev_q <= new_lvl;
    end
  end

  // ---------------------------------------------------------------------------
  // Oscillator enables
  // ---------------------------------------------------------------------------
  // Internal oscillators run only while current or being started,
  // which keeps the idle ones powered down.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lf_en_q  <= 1'b0;
      mf_en_q  <= 1'b0;
      hf_en_q  <= 1'b0;
      pll_en_q <= 1'b0;
      ext_en_q <= 1'b0;
    end else begin
      lf_en_q  <= en_int_d[0];
      mf_en_q  <= en_int_d[1];
      hf_en_q  <= en_int_d[2];
      pll_en_q <= pll_on & ~sleep_mode; // R22 R3
      ext_en_q <= (cfg.osc_mode != MODE_INTERNAL_OSC_BLOCK) & ~sleep_mode;
    end
  end

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  // Read data is zero outside the cycle after a read.
  // Control bit 2 is not stored and reads zero.
  assign wr_ctrl = reg_req.wr & (reg_req.addr == CTRL_OFF);
  assign ctrl_rd = {sw_pll_q, freq_q, 1'b0, scs_q};
  assign stat_rd = {pin_s2_q.sec_rdy, pll_rdy_q, startup_timeout_status_q, rdy_q[2], rdy_q[2], rdy_q[1], rdy_q[0], rdy_q[2]}; // R7
  assign rd_mux  = (reg_req.addr == CTRL_OFF) ? ctrl_rd :
                   (reg_req.addr == STAT_OFF) ? stat_rd : 8'h00;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_pll_q <= PLL_RST;
      freq_q   <= FREQ_RST; // R1
      scs_q    <= SCS_RST; // R9
      rdata_q  <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        sw_pll_q <= reg_req.wdata[CTRL_PLL_BIT];
        freq_q   <= reg_req.wdata[CTRL_FREQ_LSB +: 4];
        scs_q    <= reg_req.wdata[CTRL_SCS_LSB +: 2];
      end
      rdata_q <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

endmodule : clk_switch

// >>> verif/clk_switch_assertions.sv
// Port assertions for the system clock select and switch block.
// Assumes one clock, ref_clk, and arst_n as an asynchronous active-low reset.
`timescale 1ns/1ps

module clk_switch_chk
  import clk_switch_pkg::*;
#(
  parameter int unsigned PLL_LOCK = PLL_LOCK_CYC
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // Register port
  input wire reg_req_t   reg_req,
  input wire logic [7:0] rdata_q,
  // Configuration, power and outputs
  input wire cfg_word_t  cfg,
  input wire logic       sleep_mode,
  input wire logic       mf_en_q,
  input wire logic       pll_en_q,
  input wire logic       ext_en_q,
  input wire logic       sysclk_q
);
  // ------------
  // Helper logic
  // ------------
  // Until software writes the control word it must still read as its reset value.
  logic wrote_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) wrote_q <= 1'b0;
    else if (reg_req.wr && reg_req.addr == CTRL_OFF) wrote_q <= 1'b1;
  end

  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ----------
  // Properties
  // ----------
  ctrl_reset_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == CTRL_OFF && !wrote_q |-> rdata_q == 8'h38)
    else $error("control word differs from its reset value");
  rd_idle_a: assert property (!$past(reg_req.rd) |-> rdata_q == 8'h00)
    else $error("read data not zero outside a read");
  mf_stat_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == STAT_OFF && rdata_q[2] |-> $past(mf_en_q) || $past(mf_en_q, 2))
    else $error("mid oscillator reported ready while off");
  pll_cfg_a: assert property (cfg.pll_enable && !sleep_mode |=> pll_en_q)
    else $error("pll off although configuration enables it");
  ext_off_a: assert property (cfg.osc_mode == MODE_INTERNAL_OSC_BLOCK |=> !ext_en_q)
    else $error("external oscillator enabled in internal mode");
  ext_on_a: assert property (cfg.osc_mode != MODE_INTERNAL_OSC_BLOCK && !sleep_mode |=> ext_en_q)
    else $error("external oscillator not enabled");
  sleep_low_a: assert property (sleep_mode [*3] |-> !sysclk_q)
    else $error("system clock runs during sleep");
  sleep_startup_timeout_status_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == STAT_OFF && $past(sleep_mode, 2) && $past(sleep_mode, 3) |-> !rdata_q[5])
    else $error("timeout status set during sleep");
  warm_low_a: assert property ($fell(sleep_mode) && cfg.osc_mode == MODE_INTERNAL_OSC_BLOCK |-> !sysclk_q [*8])
    else $error("internal clock used without warm-up");
  hi_min_a: assert property (disable iff (!arst_n || sleep_mode) $rose(sysclk_q) |=> sysclk_q)
    else $error("system clock high pulse of one cycle");
  lo_min_a: assert property (disable iff (!arst_n || sleep_mode) $fell(sysclk_q) |=> !sysclk_q)
    else $error("system clock low pulse of one cycle");
endmodule : clk_switch_chk

bind clk_switch clk_switch_chk #(.PLL_LOCK(PLL_LOCK)) i_chk (
  .ref_clk    (ref_clk),
  .arst_n     (arst_n),
  .reg_req    (reg_req),
  .rdata_q    (rdata_q),
  .cfg        (cfg),
  .sleep_mode (sleep_mode),
  .mf_en_q    (mf_en_q),
  .pll_en_q   (pll_en_q),
  .ext_en_q   (ext_en_q),
  .sysclk_q   (sysclk_q)
);

// >>> verif/test_clk_switch.sv
// Self-checking bench for the system clock select and switch block.
// Assumes the package is compiled first; oscillators are modelled as divided ref_clk levels.
`timescale 1ns/1ps

`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %0t %s", $time, m); end end

module test_clk_switch
  import clk_switch_pkg::*;
;
  logic       ref_clk    = 1'b0;
  logic       arst_n     = 1'b0;
  reg_req_t   req        = '0;
  cfg_word_t  cfg        = '{MODE_INTERNAL_OSC_BLOCK, 1'b0, 1'b0};
  logic       sleep_mode = 1'b0;
  logic       sec_rdy    = 1'b0;
  osc_pins_t  pins       = '0;
  logic [6:0] cnt_q      = '0;
  logic [7:0] rdata_q;
  logic       lf_en_q, mf_en_q, hf_en_q, pll_en_q, ext_en_q, sysclk_q;
  int         err_count   = 0;
  int         checks_done = 0;

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ------------------
  // Oscillator models
  // ------------------
  // A disabled oscillator stands still, so a wrong enable shows up as a stalled clock.
  always @(posedge ref_clk) begin
    cnt_q        <= cnt_q + 7'h01;
    pins.lf      <= lf_en_q & cnt_q[6];
    pins.mf      <= mf_en_q & cnt_q[3];
    pins.hf      <= hf_en_q & cnt_q[2];
    pins.pll     <= pll_en_q & cnt_q[1];
    pins.ext     <= ext_en_q & cnt_q[2];
    pins.sec     <= cnt_q[5];
    pins.sec_rdy <= sec_rdy;
  end

  clk_switch #(.PLL_LOCK(20)) i_dut (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .reg_req    (req),
    .rdata_q    (rdata_q),
    .cfg        (cfg),
    .sleep_mode (sleep_mode),
    .power_up_timer_done  (1'b1),
    .osc_pins   (pins),
    .lf_en_q    (lf_en_q),
    .mf_en_q    (mf_en_q),
    .hf_en_q    (hf_en_q),
    .pll_en_q   (pll_en_q),
    .ext_en_q   (ext_en_q),
    .sysclk_q   (sysclk_q)
  );

  // ------------
  // Bus and tools
  // ------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    cyc(1);
    req.wr <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    req.addr <= a;
    req.rd   <= 1'b1;
    cyc(1);
    req.rd <= 1'b0;
    cyc(1);
    d = rdata_q;
  endtask : rd

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Width in ref_clk cycles of the next whole high phase of the system clock.
  task automatic hi_width(output int w);
    int n;
    w = 0;
    for (n = 0; sysclk_q !== 1'b0 && n < 3000; n++) cyc(1);
    for (; sysclk_q !== 1'b1 && n < 3000; n++) cyc(1);
    for (; sysclk_q === 1'b1 && n < 3000; n++) begin
      cyc(1);
      w++;
    end
    if (n >= 3000) begin
      err_count++;
      $display("[FAIL] %0t system clock stalled", $time);
      give_verdict();
    end
  endtask : hi_width

  // ---------
  // Scenarios
  // ---------
  task automatic t_regs();
    logic [7:0] d;
    rd(CTRL_OFF, d);
    `CHK(d, 8'h38, "control reset value")
    rd(4'h5, d);
    `CHK(d, 8'h00, "unmapped read")
    wr(CTRL_OFF, 8'h7f);
    rd(CTRL_OFF, d);
    `CHK(d, 8'h7b, "control bit 2")
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(1);
    rd(CTRL_OFF, d);
    `CHK(d, 8'h38, "control after second reset")
  endtask : t_regs

  task automatic t_internal();
    logic [7:0] d;
    int w;
    cyc(800);
    hi_width(w);
    `CHK(w, 8, "default mid clock")
    rd(STAT_OFF, d);
    `CHK({d[4], d[2]}, 2'b01, "status after reset")
    wr(CTRL_OFF, 8'h30);
    cyc(30);
    hi_width(w);
    `CHK(w, 16, "same source change")
    wr(CTRL_OFF, 8'h78);
    cyc(30);
    hi_width(w);
    `CHK(w, 16, "old clock kept during warm-up")
    cyc(500);
    hi_width(w);
    `CHK(w, 4, "high clock")
    rd(STAT_OFF, d);
    `CHK({d[4], d[2]}, 2'b10, "status after high switch")
    `CHK({hf_en_q, mf_en_q, lf_en_q}, 3'b100, "only high oscillator on")
    sleep_mode <= 1'b1;
    cyc(4);
    sleep_mode <= 1'b0;
    cyc(300);
    `CHK(sysclk_q, 1'b0, "held during warm-up after wake")
    cyc(200);
  endtask : t_internal

  task automatic t_pll();
    int w;
    wr(CTRL_OFF, 8'hf0);
    cyc(100);
    `CHK(pll_en_q, 1'b1, "software pll enable")
    hi_width(w);
    `CHK(w, 2, "pll clock")
    cfg.pll_enable <= 1'b1;
    wr(CTRL_OFF, 8'h70);
    cyc(60);
    hi_width(w);
    `CHK(w, 2, "configured pll removes plain code")
    wr(CTRL_OFF, 8'h78);
    cyc(60);
    `CHK(pll_en_q, 1'b1, "pll kept on")
    cfg.pll_enable <= 1'b0;
    cyc(3);
    `CHK(pll_en_q, 1'b0, "pll released")
  endtask : t_pll

  task automatic t_sources();
    logic [7:0] d;
    int w;
    wr(CTRL_OFF, 8'h00);
    cyc(900);
    hi_width(w);
    `CHK(w, 64, "low clock")
    sec_rdy <= 1'b1;
    cyc(4);
    rd(STAT_OFF, d);
    `CHK(d[7], 1'b1, "secondary ready")
    wr(CTRL_OFF, 8'h01);
    cyc(260);
    hi_width(w);
    `CHK(w, 32, "secondary clock")
    `CHK({hf_en_q, mf_en_q, lf_en_q}, 3'b000, "internal oscillators off")
  endtask : t_sources

  task automatic t_two_speed();
    logic [7:0] d;
    int w;
    cfg.osc_mode   <= MODE_XT;
    cfg.switchover <= 1'b1;
    wr(CTRL_OFF, 8'h38);
    cyc(600);
    hi_width(w);
    rd(STAT_OFF, d);
    `CHK({w[3:0], d[5]}, 5'h10, "internal during start-up")
    cyc(300);
    sleep_mode <= 1'b1;
    cyc(10);
    `CHK(sysclk_q, 1'b0, "clock stopped in sleep")
    rd(STAT_OFF, d);
    `CHK(d[5], 1'b0, "timeout clear after abort")
    sleep_mode <= 1'b0;
    cyc(600);
    hi_width(w);
    `CHK(w, 8, "internal after wake")
    cyc(6000);
    rd(STAT_OFF, d);
    `CHK(d[5], 1'b0, "count not yet done")
    cyc(2500);
    rd(STAT_OFF, d);
    `CHK(d[5], 1'b1, "timeout after count")
    hi_width(w);
    `CHK(w, 4, "external crystal clock")
    rd(CTRL_OFF, d);
    `CHK(d, 8'h38, "source select untouched")
    cfg.osc_mode <= 3'h3;
    sleep_mode   <= 1'b1;
    cyc(10);
    sleep_mode <= 1'b0;
    cyc(100);
    hi_width(w);
    rd(STAT_OFF, d);
    `CHK({w[3:0], d[5]}, 5'h09, "plain external at once")
  endtask : t_two_speed

  initial begin
    cyc(8);
    arst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_internal();
    t_pll();
    t_sources();
    t_two_speed();
    give_verdict();
  end
endmodule : test_clk_switch
